// File: pdrio_pkg.sv
// Shared constants for the positioner drive and readout logic.
`default_nettype none
package pdrio_pkg;
   // Processor write selects for the four command ports.
   localparam logic [1:0] PDRIO_WR_DRIVE_LOW = 2'h0;
   localparam logic [1:0] PDRIO_WR_DRIVE_HIGH = 2'h1;
   localparam logic [1:0] PDRIO_WR_AUX_LOW = 2'h2;
   localparam logic [1:0] PDRIO_WR_AUX_HIGH = 2'h3;
   // Processor read selects; the remote bytes follow the ports.
   localparam logic [3:0] PDRIO_RD_DRIVE_LOW = 4'h0;
   localparam logic [3:0] PDRIO_RD_DRIVE_HIGH = 4'h1;
   localparam logic [3:0] PDRIO_RD_AUX_LOW = 4'h2;
   localparam logic [3:0] PDRIO_RD_AUX_HIGH = 4'h3;
   localparam logic [3:0] PDRIO_RD_REMOTE0 = 4'h4;
   localparam logic [3:0] PDRIO_RD_ADC_LOW = 4'hb;
   localparam logic [3:0] PDRIO_RD_ADC_HIGH = 4'hc;
   // Remote receive geometry: seven bytes, 56 bits per transfer.
   localparam int PDRIO_NUM_REMOTE = 7;
   localparam int PDRIO_BYTE_W = 8;
   localparam int PDRIO_FIFO_DEPTH = 8;
   localparam logic [2:0] PDRIO_TOP_REG = 3'h6;
   // Drive command port high bit positions.
   localparam int PDRIO_B_INHIBIT = 4;
   localparam int PDRIO_B_AMP_RESET = 5;
   localparam int PDRIO_B_BRAKE = 6;
   localparam int PDRIO_B_THREE_PHASE = 7;
   // Aux port fields.
   localparam int PDRIO_MUX_W = 3;
   localparam int PDRIO_LAMP_W = 6;
   localparam int PDRIO_SPARE_W = 2;
   localparam int PDRIO_AUX_OUT_W = 3;
   // D/A and A/D widths.
   localparam int PDRIO_DAC_W = 12;
   localparam int PDRIO_HALF_W = 6;
   localparam logic [7:0] PDRIO_PORT_RST = 8'h00;
   localparam logic [11:0] PDRIO_DAC_ZERO = 12'h000;
   localparam logic [3:0] PDRIO_NIBBLE_ZERO = 4'h0;
endpackage : pdrio_pkg
`default_nettype wire

// File: pdrio_byte_if.sv
`timescale 1ns/1ns
`default_nettype none
// Byte stream with valid and ready between the receiver, the FIFO and the top.
interface pdrio_byte_if;
   logic [7:0] data;  // Byte payload.
   logic valid;  // Source holds a byte.
   logic ready;  // Sink takes the byte this cycle when valid.
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : pdrio_byte_if
`default_nettype wire

// File: pdrio_fifo.sv
`timescale 1ns/1ns
`default_nettype none
// Small synchronous FIFO; full and empty come straight from the count.
module pdrio_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_srst,
   pdrio_byte_if.snk wr,
   pdrio_byte_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];  // Storage array.
   logic [AW-1:0] wptr_reg;  // Write pointer.
   logic [AW-1:0] rptr_reg;  // Read pointer.
   logic [AW:0] count_reg;  // Words held.
   wire push = wr.valid && wr.ready;
   wire pop = rd.valid && rd.ready;
   assign wr.ready = (count_reg != (AW+1)'(DEPTH));
   assign rd.valid = (count_reg != '0);
   assign rd.data = mem[rptr_reg];

   // Pointers wrap by compare so that a depth off a power of two still works.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
         end
         if (pop) begin
            rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // The array has no reset; only written words are ever read.
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wptr_reg] <= wr.data;
      end
   end
endmodule : pdrio_fifo
`default_nettype wire

// File: pdrio_serial_rx.sv
`timescale 1ns/1ns
`default_nettype none
// Remote serial receiver: samples data on the rising edge of the remote clock.
module pdrio_serial_rx (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_clear,
   input wire logic i_ser_clk,
   input wire logic i_ser_data,
   output logic o_overrun,
   pdrio_byte_if.src out
);
   import pdrio_pkg::*;
   logic [1:0] clk_sync_reg;  // Two flops on the remote clock.
   logic [1:0] dat_sync_reg;  // Two flops on the remote data.
   logic clk_prev_reg;  // Last synchronised clock level.
   logic [7:0] shift_reg;  // Bits being assembled, first bit lands in MSB.
   logic [2:0] bit_cnt_reg;  // Bits in the current byte.
   logic [7:0] hold_reg;  // Finished byte awaiting the FIFO.
   logic hold_valid_reg;  // Finished byte is present.
   logic overrun_reg;  // A byte was finished while the last still waited.
   // Rising edge is seen on synchronised samples only.
   wire rise = clk_sync_reg[1] && !clk_prev_reg;
   wire byte_done = rise && (bit_cnt_reg == 3'h7);
   wire [7:0] shift_next = {shift_reg[6:0], dat_sync_reg[1]};
   assign out.data = hold_reg;
   assign out.valid = hold_valid_reg;
   assign o_overrun = overrun_reg;

   // Synchronisers; stage 0 feeds stage 1 and nothing else.
   always_ff @(posedge i_clk) begin
      clk_sync_reg <= {clk_sync_reg[0], i_ser_clk}; // R25
      dat_sync_reg <= {dat_sync_reg[0], i_ser_data}; // R25
      clk_prev_reg <= clk_sync_reg[1];
   end

   // The remote edge sits mid-bit, so the data sample is settled there.
   always_ff @(posedge i_clk) begin
      if (i_srst || i_clear) begin
         bit_cnt_reg <= '0;
         shift_reg <= '0;
      end else if (rise) begin
         shift_reg <= shift_next; // R6
         bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
   end

   // A byte waits here; bits cannot be stalled, so a lost byte is flagged.
   always_ff @(posedge i_clk) begin
      if (i_srst || i_clear) begin
         hold_valid_reg <= 1'b0;
         hold_reg <= '0;
         overrun_reg <= 1'b0;
      end else begin
         if (byte_done) begin
            hold_reg <= shift_next;
            hold_valid_reg <= 1'b1;
            overrun_reg <= overrun_reg || (hold_valid_reg && !out.ready);
         end else if (out.ready) begin
            hold_valid_reg <= 1'b0;
         end
      end
   end
endmodule : pdrio_serial_rx
`default_nettype wire

// File: pdrio_top.sv
// How it works
// (R1) Drive port: 12-bit D/A, inhibit, reset, brake, power.
// (R2) Aux port: mux address, six lamps, two spares.
// (R3) Aux high bits 3-7 read operator and alarm inputs.
// (R4) Firmware decodes input polarities itself.
// (R5) Serial data fills seven byte-readable registers.
// (R6) Remote clock rises mid-bit; sample on rise.
// (R7) Request strobe clears all seven receive registers.
// (R8) Remote sends data and clocks after request.
// (R9) Firmware checks top register bits 7:6 equal 10.
// (R10) One transfer is 56 bits, seven bytes.
// (R11) D/A register holds 12-bit two's complement.
// (R12) Two halves load together on load strobe.
// (R13) Reset or lockout clears the D/A register.
// (R14) Active-low strobe starts a conversion.
// (R15) A/D low byte, then high nibble on bits 7:4.
// (R16) Firmware masks low nibble, joins both reads.
// (R17) Chip select for convert and both reads.
// (R18) Low conversion-done raises interrupt request zero.
// (R19) Open limit loop drops lockout low.
// (R20) Lockout is limit loop AND cable interlock.
// (R21) Brake, inhibit, reset pass only while lockout high.
// (R22) Lockout readable on aux high bit 4.
// (R23) Firmware keeps amplifiers inhibited while idle.
// (R24) Firmware delays three-phase power at power-up.
// (R25) Outside inputs pass two synchronising flops.
`timescale 1ns/1ns
`default_nettype none
module pdrio_top (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_wr_en,
   input wire logic [1:0] i_wr_sel,
   input wire logic [7:0] i_wr_data,
   input wire logic i_rd_en,
   input wire logic [3:0] i_rd_sel,
   output logic [7:0] o_rd_data,
   input wire logic i_remote_request,
   input wire logic i_dac_load_strobe,
   input wire logic i_adc_convert_strobe_n,
   input wire logic i_remote_ser_clk,
   input wire logic i_remote_ser_data,
   input wire logic i_limit_loop_signal,
   input wire logic i_cable_interlock,
   input wire logic i_emergency_stop,
   input wire logic i_computer_mode,
   input wire logic i_slew_down_n,
   input wire logic i_slew_up_n,
   input wire logic [pdrio_pkg::PDRIO_DAC_W-1:0] i_adc_data,
   input wire logic i_adc_conversion_done_n,
   output logic [pdrio_pkg::PDRIO_DAC_W-1:0] o_dac_value,
   output logic o_amp_inhibit,
   output logic o_amp_reset,
   output logic o_brake_release,
   output logic o_three_phase_power,
   output logic [pdrio_pkg::PDRIO_MUX_W-1:0] o_analog_mux_select,
   output logic [pdrio_pkg::PDRIO_LAMP_W-1:0] o_panel_lamps,
   output logic [pdrio_pkg::PDRIO_SPARE_W-1:0] o_spare_out,
   output logic o_adc_chip_select_n,
   output logic o_adc_convert_n,
   output logic o_external_irq_zero,
   output logic o_drive_lockout,
   output logic o_remote_overrun
);
   import pdrio_pkg::*;

   // Byte streams from receiver to FIFO and from FIFO to the register bank.
   pdrio_byte_if rx_bus ();
   pdrio_byte_if bank_bus ();

   logic [7:0] drive_cmd_port_low_reg;  // D/A low eight bits.
   logic [7:0] drive_cmd_port_high_reg;  // D/A high nibble and discretes.
   logic [7:0] aux_cmd_port_low_reg;  // Mux address and lamps.
   logic [7:0] aux_mixed_port_high_reg;  // Lamp, spares; bits 3-7 are inputs.
   logic [7:0] remote_reg [PDRIO_NUM_REMOTE];  // Receive bank.
   logic [2:0] fill_idx_reg;  // Next bank slot to fill, top first.
   logic shift_mode_ctl_a_reg;  // Bank mode control, high means clear.
   logic shift_mode_ctl_b_reg;  // Bank mode control, low with a high means clear.
   logic [1:0] limit_sync_reg;  // Limit loop synchroniser.
   logic [1:0] lock_sync_reg;  // Cable interlock synchroniser.
   logic [1:0] estop_sync_reg;  // Emergency stop synchroniser.
   logic [1:0] comp_sync_reg;  // Computer mode synchroniser.
   logic [1:0] sdn_sync_reg;  // Slew down synchroniser.
   logic [1:0] sup_sync_reg;  // Slew up synchroniser.
   logic [1:0] done_sync_reg;  // Conversion done synchroniser.
   logic [PDRIO_DAC_W-1:0] adc_sync0_reg;  // A/D data first stage.
   logic [PDRIO_DAC_W-1:0] adc_sync1_reg;  // A/D data second stage.
   logic lockout_reg;  // Drive lockout, high means drive allowed.
   logic [PDRIO_DAC_W-1:0] dac_reg;  // D/A holding register.
   logic [7:0] rd_data_reg;  // Read answer.
   logic inhibit_reg;  // Gated inhibit discrete.
   logic amp_reset_reg;  // Gated amplifier reset discrete.
   logic brake_reg;  // Gated brake release discrete.
   logic three_phase_reg;  // Three-phase power discrete.
   logic cs_n_reg;  // Converter chip select.
   logic conv_n_reg;  // Converter start.
   logic irq_reg;  // Interrupt request zero.
   logic overrun;  // From the receiver.

   // Decodes.
   wire wr_drive_low = i_wr_en && (i_wr_sel == PDRIO_WR_DRIVE_LOW);
   wire wr_drive_high = i_wr_en && (i_wr_sel == PDRIO_WR_DRIVE_HIGH);
   wire wr_aux_low = i_wr_en && (i_wr_sel == PDRIO_WR_AUX_LOW);
   wire wr_aux_high = i_wr_en && (i_wr_sel == PDRIO_WR_AUX_HIGH);
   wire rd_adc_low = i_rd_en && (i_rd_sel == PDRIO_RD_ADC_LOW);
   wire rd_adc_high = i_rd_en && (i_rd_sel == PDRIO_RD_ADC_HIGH);
   wire convert_now = !i_adc_convert_strobe_n; // R14
   wire clear_bank = shift_mode_ctl_a_reg && !shift_mode_ctl_b_reg; // R7
   wire lockout_next = limit_sync_reg[1] && lock_sync_reg[1]; // R19 R20
   wire [PDRIO_DAC_W-1:0] dac_cmd = {drive_cmd_port_high_reg[3:0], drive_cmd_port_low_reg};
   wire [3:0] rd_remote_idx = i_rd_sel - PDRIO_RD_REMOTE0;
   wire rd_is_remote = (i_rd_sel >= PDRIO_RD_REMOTE0) && (i_rd_sel < PDRIO_RD_ADC_LOW);
   // Aux high readback: spares and lamp from the port, then the five inputs.
   wire [7:0] aux_high_rd = {sup_sync_reg[1], sdn_sync_reg[1], comp_sync_reg[1],
                             lockout_reg, estop_sync_reg[1],
                             aux_mixed_port_high_reg[2:0]}; // R3 R22
   wire [7:0] rd_next =
      (i_rd_sel == PDRIO_RD_DRIVE_LOW) ? drive_cmd_port_low_reg :
      (i_rd_sel == PDRIO_RD_DRIVE_HIGH) ? drive_cmd_port_high_reg :
      (i_rd_sel == PDRIO_RD_AUX_LOW) ? aux_cmd_port_low_reg :
      (i_rd_sel == PDRIO_RD_AUX_HIGH) ? aux_high_rd :
      rd_is_remote ? remote_reg[rd_remote_idx[2:0]] : // R5
      (i_rd_sel == PDRIO_RD_ADC_LOW) ? adc_sync1_reg[7:0] : // R15
      (i_rd_sel == PDRIO_RD_ADC_HIGH) ? {adc_sync1_reg[11:8], PDRIO_NIBBLE_ZERO} : // R15
      PDRIO_PORT_RST;

   // The bank never refuses a byte except in the clear cycle.
   assign bank_bus.ready = !clear_bank;

   pdrio_serial_rx u_rx (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_clear(clear_bank),
      .i_ser_clk(i_remote_ser_clk),
      .i_ser_data(i_remote_ser_data),
      .o_overrun(overrun),
      .out(rx_bus.src)
   );

   pdrio_fifo #(
      .WIDTH(PDRIO_BYTE_W),
      .DEPTH(PDRIO_FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_srst(i_srst || clear_bank),
      .wr(rx_bus.snk),
      .rd(bank_bus.src)
   );

   // Synchronisers for every pin that the loop, the operator or the converter drives.
   always_ff @(posedge i_clk) begin
      limit_sync_reg <= {limit_sync_reg[0], i_limit_loop_signal}; // R25
      lock_sync_reg <= {lock_sync_reg[0], i_cable_interlock}; // R25
      estop_sync_reg <= {estop_sync_reg[0], i_emergency_stop};
      comp_sync_reg <= {comp_sync_reg[0], i_computer_mode};
      sdn_sync_reg <= {sdn_sync_reg[0], i_slew_down_n};
      sup_sync_reg <= {sup_sync_reg[0], i_slew_up_n};
      done_sync_reg <= {done_sync_reg[0], i_adc_conversion_done_n};
      adc_sync0_reg <= i_adc_data;
      adc_sync1_reg <= adc_sync0_reg;
   end

   // Command ports; the lamp and spare bits share the mixed port's low bits.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         drive_cmd_port_low_reg <= PDRIO_PORT_RST;
         drive_cmd_port_high_reg <= PDRIO_PORT_RST;
         aux_cmd_port_low_reg <= PDRIO_PORT_RST;
         aux_mixed_port_high_reg <= PDRIO_PORT_RST;
      end else begin
         if (wr_drive_low) drive_cmd_port_low_reg <= i_wr_data; // R1
         if (wr_drive_high) drive_cmd_port_high_reg <= i_wr_data; // R1
         if (wr_aux_low) aux_cmd_port_low_reg <= i_wr_data; // R2
         if (wr_aux_high) aux_mixed_port_high_reg <= i_wr_data; // R2
      end
   end

   // A request drives the mode controls to clear one cycle later, for as long as the request is held.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         shift_mode_ctl_a_reg <= 1'b0;
         shift_mode_ctl_b_reg <= 1'b1;
      end else begin
         shift_mode_ctl_a_reg <= i_remote_request; // R7
         shift_mode_ctl_b_reg <= !i_remote_request; // R7
      end
   end

   // Bytes arrive first-bit-first, so the first one is the top register.
   // Bytes beyond the seventh are dropped; a transfer carries only 56 bits.
   always_ff @(posedge i_clk) begin
      if (i_srst || clear_bank) begin
         fill_idx_reg <= PDRIO_TOP_REG;
         for (int i = 0; i < PDRIO_NUM_REMOTE; i++) begin
            remote_reg[i] <= PDRIO_PORT_RST; // R7
         end
      end else if (bank_bus.valid && (fill_idx_reg <= PDRIO_TOP_REG)) begin
         remote_reg[fill_idx_reg] <= bank_bus.data; // R5 R10
         fill_idx_reg <= fill_idx_reg - 1'b1; // R10
      end
   end

   // Lockout is registered once after the synchronisers.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         lockout_reg <= 1'b0;
      end else begin
         lockout_reg <= lockout_next; // R20
      end
   end

   // Both halves load together from the ports; lockout wins over a load.
   always_ff @(posedge i_clk) begin
      if (i_srst || !lockout_reg) begin
         dac_reg <= PDRIO_DAC_ZERO; // R13
      end else if (i_dac_load_strobe) begin
         dac_reg[PDRIO_HALF_W-1:0] <= dac_cmd[PDRIO_HALF_W-1:0]; // R11 R12
         dac_reg[PDRIO_DAC_W-1:PDRIO_HALF_W] <= dac_cmd[PDRIO_DAC_W-1:PDRIO_HALF_W]; // R12
      end
   end

   // Discretes pass only while lockout is high; power is not gated by lockout.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         inhibit_reg <= 1'b0;
         amp_reset_reg <= 1'b0;
         brake_reg <= 1'b0;
         three_phase_reg <= 1'b0;
      end else begin
         inhibit_reg <= drive_cmd_port_high_reg[PDRIO_B_INHIBIT] && lockout_reg; // R21
         amp_reset_reg <= drive_cmd_port_high_reg[PDRIO_B_AMP_RESET] && lockout_reg; // R21
         brake_reg <= drive_cmd_port_high_reg[PDRIO_B_BRAKE] && lockout_reg; // R21
         three_phase_reg <= drive_cmd_port_high_reg[PDRIO_B_THREE_PHASE]; // R1
      end
   end

   // Converter strobes are registered so the chip sees clean edges.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cs_n_reg <= 1'b1;
         conv_n_reg <= 1'b1;
         irq_reg <= 1'b0;
         rd_data_reg <= PDRIO_PORT_RST;
      end else begin
         cs_n_reg <= !(convert_now || rd_adc_low || rd_adc_high); // R17
         conv_n_reg <= !convert_now; // R14
         irq_reg <= !done_sync_reg[1]; // R18
         rd_data_reg <= i_rd_en ? rd_next : rd_data_reg;
      end
   end

   assign o_rd_data = rd_data_reg;
   assign o_dac_value = dac_reg;
   assign o_amp_inhibit = inhibit_reg;
   assign o_amp_reset = amp_reset_reg;
   assign o_brake_release = brake_reg;
   assign o_three_phase_power = three_phase_reg;
   assign o_analog_mux_select = aux_cmd_port_low_reg[PDRIO_MUX_W-1:0]; // R2
   assign o_panel_lamps = {aux_mixed_port_high_reg[0], aux_cmd_port_low_reg[7:PDRIO_MUX_W]};
   assign o_spare_out = aux_mixed_port_high_reg[PDRIO_AUX_OUT_W-1:1];
   assign o_adc_chip_select_n = cs_n_reg;
   assign o_adc_convert_n = conv_n_reg;
   assign o_external_irq_zero = irq_reg;
   assign o_drive_lockout = lockout_reg;
   assign o_remote_overrun = overrun;

   // Checks on the design's own outputs.
   property p_dac_clear;
      @(posedge i_clk) disable iff (i_srst) !lockout_reg |=> (dac_reg == PDRIO_DAC_ZERO);
   endproperty
   a_dac_clear: assert property (p_dac_clear) else $error("dac not cleared"); // R13
   property p_dac_load;
      @(posedge i_clk) disable iff (i_srst)
         (i_dac_load_strobe && lockout_reg) |=> (dac_reg == $past(dac_cmd));
   endproperty
   a_dac_load: assert property (p_dac_load) else $error("dac load wrong"); // R12
   property p_dac_hold;
      @(posedge i_clk) disable iff (i_srst)
         (!i_dac_load_strobe && lockout_reg && $past(lockout_reg)) |=> $stable(dac_reg);
   endproperty
   a_dac_hold: assert property (p_dac_hold) else $error("dac moved without load"); // R12
   property p_brake_gate;
      @(posedge i_clk) disable iff (i_srst) !lockout_reg |=> !brake_reg && !inhibit_reg && !amp_reset_reg;
   endproperty
   a_brake_gate: assert property (p_brake_gate) else $error("discrete passed in lockout"); // R21
   // The edge that ends reset still loads the reset value, so it starts no check.
   property p_lockout;
      @(posedge i_clk) disable iff (i_srst) !i_srst |=> (lockout_reg == $past(lockout_next));
   endproperty
   a_lockout: assert property (p_lockout) else $error("lockout not loop and interlock"); // R20
   property p_cs;
      @(posedge i_clk) disable iff (i_srst) (convert_now || rd_adc_low || rd_adc_high) |=> !cs_n_reg;
   endproperty
   a_cs: assert property (p_cs) else $error("chip select missing"); // R17
   property p_conv;
      @(posedge i_clk) disable iff (i_srst) conv_n_reg |-> !$past(convert_now);
   endproperty
   a_conv: assert property (p_conv) else $error("convert start wrong"); // R14
   property p_irq;
      @(posedge i_clk) disable iff (i_srst) $fell(done_sync_reg[1]) |=> irq_reg;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not raised"); // R18
   property p_clear;
      @(posedge i_clk) disable iff (i_srst) i_remote_request |=> ##1 (remote_reg[PDRIO_TOP_REG] == PDRIO_PORT_RST);
   endproperty
   a_clear: assert property (p_clear) else $error("bank not cleared"); // R7
   property p_adc_high;
      @(posedge i_clk) disable iff (i_srst) rd_adc_high |=> (rd_data_reg[3:0] == PDRIO_NIBBLE_ZERO);
   endproperty
   a_adc_high: assert property (p_adc_high) else $error("low nibble driven"); // R15
   c_remote_full: cover property (@(posedge i_clk) fill_idx_reg == 3'h7);
   c_dac_load: cover property (@(posedge i_clk) i_dac_load_strobe && lockout_reg);
   c_lockout_drop: cover property (@(posedge i_clk) $fell(lockout_reg));
endmodule : pdrio_top
`default_nettype wire

// File: pdrio_remote_model.sv
`timescale 1ns/1ns
`default_nettype none
// Remote serial unit: sends one frame MSB first when i_send rises.
module pdrio_remote_model (
   input wire logic i_send,
   input wire logic [55:0] i_frame,
   output logic o_ser_clk,
   output logic o_ser_data
);
   // The link clock rests low between frames, as the remote unit only clocks within a frame.
   initial begin
      o_ser_clk = 1'b0;
      o_ser_data = 1'b0;
   end
   // Each bit is set up half a period before the rising clock edge, so the edge is mid-bit.
   always @(posedge i_send) begin
      for (int k = 55; k >= 0; k--) begin
         o_ser_data = i_frame[k];
         #200 o_ser_clk = 1'b1;
         #200 o_ser_clk = 1'b0;
      end
      // The line is no longer held after the frame, so it shows the inverse of the last bit.
      o_ser_data = ~o_ser_data;
   end
endmodule : pdrio_remote_model
`default_nettype wire

// File: pdrio_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module pdrio_top_tb_top;
   import pdrio_pkg::*;
   logic i_clk = 1'b0, i_srst = 1'b1, i_wr_en = 1'b0, i_rd_en = 1'b0, i_remote_request = 1'b0;
   logic [1:0] i_wr_sel = 2'h0;
   logic [7:0] i_wr_data = 8'h00;
   logic [3:0] i_rd_sel = 4'h0;
   logic i_dac_load_strobe = 1'b0, i_adc_convert_strobe_n = 1'b1, i_limit_loop_signal = 1'b1;
   logic i_cable_interlock = 1'b1, i_emergency_stop = 1'b1, i_computer_mode = 1'b0;
   logic i_slew_down_n = 1'b1, i_slew_up_n = 1'b0, i_adc_conversion_done_n = 1'b1, send = 1'b0;
   logic [11:0] i_adc_data = 12'habc;
   logic [55:0] frame = 56'ha1223344556677; // Top byte opens with 10, the loaded marker.
   logic i_remote_ser_clk, i_remote_ser_data, o_adc_chip_select_n, o_adc_convert_n;
   logic [7:0] o_rd_data;
   logic [7:0] adc_lo;  // Low A/D byte kept until the high byte is read.
   logic [11:0] o_dac_value;
   logic o_amp_inhibit, o_amp_reset, o_brake_release, o_three_phase_power;
   logic [2:0] o_analog_mux_select;
   logic [5:0] o_panel_lamps;
   logic [1:0] o_spare_out;
   logic o_external_irq_zero, o_drive_lockout, o_remote_overrun;
   int n_errors = 0;
   int total_checks = 0;
   pdrio_top i_dut (.i_clk, .i_srst, .i_wr_en, .i_wr_sel, .i_wr_data, .i_rd_en, .i_rd_sel,
      .o_rd_data, .i_remote_request, .i_dac_load_strobe, .i_adc_convert_strobe_n,
      .i_remote_ser_clk, .i_remote_ser_data, .i_limit_loop_signal, .i_cable_interlock,
      .i_emergency_stop, .i_computer_mode, .i_slew_down_n, .i_slew_up_n, .i_adc_data,
      .i_adc_conversion_done_n, .o_dac_value, .o_amp_inhibit, .o_amp_reset, .o_brake_release,
      .o_three_phase_power, .o_analog_mux_select, .o_panel_lamps, .o_spare_out,
      .o_adc_chip_select_n, .o_adc_convert_n, .o_external_irq_zero, .o_drive_lockout,
      .o_remote_overrun);
   pdrio_remote_model i_remote (.i_send(send), .i_frame(frame), .o_ser_clk(i_remote_ser_clk),
      .o_ser_data(i_remote_ser_data));
   // The 20 MHz clock.
   initial begin
      forever #25 i_clk = ~i_clk;
   end
   // Every comparison goes through here so that counts stay consistent.
   task automatic chk(input string name, input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // Waits n edges, then lets the updates of the last edge settle.
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : wt
   task automatic wr(input logic [1:0] sel, input logic [7:0] data);
      @(posedge i_clk);
      i_wr_en <= 1'b1;
      i_wr_sel <= sel;
      i_wr_data <= data;
      @(posedge i_clk);
      i_wr_en <= 1'b0;
   endtask : wr
   // Read data is registered, so it is looked at just after the edge that takes the read.
   task automatic rd(input logic [3:0] sel, input logic [7:0] exp);
      @(posedge i_clk);
      i_rd_en <= 1'b1;
      i_rd_sel <= sel;
      @(posedge i_clk);
      i_rd_en <= 1'b0;
      #1 chk("rd_data", {4'h0, o_rd_data}, {4'h0, exp});
   endtask : rd
   task automatic load_dac();
      @(posedge i_clk);
      i_dac_load_strobe <= 1'b1;
      @(posedge i_clk);
      i_dac_load_strobe <= 1'b0;
      wt(2);
   endtask : load_dac
   task automatic end_sim();
      $display("Checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   // Watchdog well beyond the roughly 620 cycles the tests need.
   initial begin
      #500000;
      n_errors++;
      end_sim();
   end
   initial begin
      repeat (5) @(posedge i_clk);
      i_srst <= 1'b0;
      wt(6);
      chk("dac_reset", o_dac_value, PDRIO_DAC_ZERO);
      rd(PDRIO_RD_DRIVE_LOW, 8'h00);
      // Drive port: value 12'h534, inhibit and brake on, reset off, power on.
      wr(PDRIO_WR_DRIVE_LOW, 8'h34);
      wr(PDRIO_WR_DRIVE_HIGH, 8'hd5);
      rd(PDRIO_RD_DRIVE_HIGH, 8'hd5);
      wt(2);
      chk("dac_early", o_dac_value, PDRIO_DAC_ZERO);
      load_dac();
      chk("dac", o_dac_value, 12'h534);
      chk("disc", {o_amp_inhibit, o_amp_reset, o_brake_release, o_three_phase_power}, 4'hb);
      // The auxiliary port and the operator inputs with their readback.
      wr(PDRIO_WR_AUX_LOW, 8'hfd);
      wr(PDRIO_WR_AUX_HIGH, 8'h05);
      rd(PDRIO_RD_AUX_LOW, 8'hfd);
      wt(2);
      chk("aux", {o_analog_mux_select, o_panel_lamps, o_spare_out}, {3'h5, 6'h3f, 2'h2});
      rd(PDRIO_RD_AUX_HIGH, 8'h5d);
      // An opened limit loop must drop lockout, clear the D/A and block the drive discretes.
      i_limit_loop_signal <= 1'b0;
      wt(6);
      chk("lock", {o_drive_lockout, o_dac_value}, {1'b0, PDRIO_DAC_ZERO});
      chk("disc_lock", {o_amp_inhibit, o_amp_reset, o_brake_release, o_three_phase_power}, 4'h1);
      rd(PDRIO_RD_AUX_HIGH, 8'h4d);
      load_dac();
      chk("dac_refused", o_dac_value, PDRIO_DAC_ZERO);
      i_limit_loop_signal <= 1'b1;
      i_cable_interlock <= 1'b0;
      wt(6);
      chk("cable", o_drive_lockout, 1'b0);
      i_cable_interlock <= 1'b1;
      wt(6);
      chk("relock", {o_drive_lockout, o_amp_inhibit}, 2'h3);
      // A/D: convert strobe, then the two byte reads with chip select each time.
      i_adc_convert_strobe_n <= 1'b0;
      @(posedge i_clk);
      i_adc_convert_strobe_n <= 1'b1;
      #1 chk("convert", {o_adc_convert_n, o_adc_chip_select_n}, 2'h0);
      rd(PDRIO_RD_ADC_LOW, 8'hbc);
      chk("cs_low", o_adc_chip_select_n, 1'b0);
      adc_lo = o_rd_data;
      rd(PDRIO_RD_ADC_HIGH, 8'ha0);
      chk("cs_high", o_adc_chip_select_n, 1'b0);
      chk("adc_word", {o_rd_data[7:4], adc_lo}, i_adc_data);
      i_adc_conversion_done_n <= 1'b0;
      wt(5);
      chk("irq", o_external_irq_zero, 1'b1);
      i_adc_conversion_done_n <= 1'b1;
      wt(5);
      chk("irq_off", o_external_irq_zero, 1'b0);
      // Remote transfer: request, one frame, then all seven bytes; first byte lands on top.
      @(posedge i_clk);
      i_remote_request <= 1'b1;
      send <= 1'b1;
      @(posedge i_clk);
      i_remote_request <= 1'b0;
      send <= 1'b0;
      wt(520);
      for (int k = 0; k < PDRIO_NUM_REMOTE; k++) begin
         rd(PDRIO_RD_REMOTE0 + 4'(k), frame[8*k +: 8]);
      end
      chk("overrun", o_remote_overrun, 1'b0);
      @(posedge i_clk);
      i_remote_request <= 1'b1;
      @(posedge i_clk);
      i_remote_request <= 1'b0;
      wt(3);
      rd(PDRIO_RD_REMOTE0 + 4'(PDRIO_TOP_REG), 8'h00);
      rd(PDRIO_RD_REMOTE0, 8'h00);
      rd(4'hd, 8'h00);
      end_sim();
   end
endmodule : pdrio_top_tb_top
`default_nettype wire
